// ---- verilog/rate_storm_pkg.sv ----
// What this block does
// [RQ1] Bit 12 turns newer limiter scheme on
// [RQ2] Per-port transmit enables at bits 11,10,9,5,3,1
// [RQ3] Per-port receive enables at bits 8,7,6,4,2,0
// [RQ4] Rate is limit slices then six zeros, kbps
// [RQ5] 0x34 holds transmit low slices, ports 5..2
// [RQ6] Port three transmit low nibble sits at 7:4
// [RQ7] 0x35 holds receive mid slices, ports 3..0
// [RQ8] Unlisted register holds remaining mid slices
// [RQ9] 0x37 holds transmit mid slices, ports 5..2
// [RQ10] 0x38 holds receive high slices, ports 4..0
// [RQ11] 0x39 holds transmit high 3..0, receive 5
// [RQ12] 0x3a holds transmit high slices, ports 5,4
// [RQ13] All enables and limit slices reset zero; code resets 0x3a to 0x0fc0, setting only bits 11:6, so transmit high slices of ports 5,4 reset to 0
// [RQ14] Storm enable bit 13 activates thresholds
// [RQ15] Storm drop bit 14 discards during storm
// [RQ16] All-100M threshold compared per 50 ms window
// [RQ17] Any-10M link uses second threshold at 0x3c
// [RQ18] 0x31 and 0x32 hold remaining low slices
// [RQ19] Enabled limit drops frames exceeding rate
// [RQ20] Storm count clears each window; storm lasts window
package rate_storm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int NUM_REGS = 12;
  localparam logic [7:0] OFF_FIRST = 8'h31;
  localparam logic [7:0] OFF_BASIC0 = 8'h31;
  localparam logic [7:0] OFF_BASIC1 = 8'h32;
  localparam logic [7:0] OFF_ENABLES = 8'h33;
  localparam logic [7:0] OFF_EXT0 = 8'h34;
  localparam logic [7:0] OFF_EXT1 = 8'h35;
  localparam logic [7:0] OFF_EXT2 = 8'h36;
  localparam logic [7:0] OFF_EXT3 = 8'h37;
  localparam logic [7:0] OFF_EXT4 = 8'h38;
  localparam logic [7:0] OFF_EXT5 = 8'h39;
  localparam logic [7:0] OFF_EXT6 = 8'h3a;
  localparam logic [7:0] OFF_STORM0 = 8'h3b;
  localparam logic [7:0] OFF_STORM1 = 8'h3c;

  localparam int IDX_BASIC0 = 0;
  localparam int IDX_BASIC1 = 1;
  localparam int IDX_ENABLES = 2;
  localparam int IDX_EXT0 = 3;
  localparam int IDX_EXT1 = 4;
  localparam int IDX_EXT2 = 5;
  localparam int IDX_EXT3 = 6;
  localparam int IDX_EXT4 = 7;
  localparam int IDX_EXT5 = 8;
  localparam int IDX_EXT6 = 9;
  localparam int IDX_STORM0 = 10;
  localparam int IDX_STORM1 = 11;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int NEW_SCHEME_POS = 12;
  localparam int STORM_DROP_POS = 14;
  localparam int STORM_EN_POS = 13;
  localparam int THRESH_W = 13;
  localparam int LIMIT_W = 11;
  localparam int RATE_SHIFT = 6;
  localparam int RATE_W = LIMIT_W + RATE_SHIFT;
  localparam logic [5:0][3:0] TX_EN_POS = {4'hb, 4'ha, 4'h9, 4'h5, 4'h3, 4'h1};
  localparam logic [5:0][3:0] RX_EN_POS = {4'h8, 4'h7, 4'h6, 4'h4, 4'h2, 4'h0};
  localparam logic [15:0] MASK_STORM0 = 16'h7fff;
  localparam logic [15:0] MASK_EXT6 = 16'h0fff;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] RST_EXT6 = 16'h0fc0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int TICK_PERIOD_US = 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_PERIOD_US;
  localparam int STORM_WINDOW_MS = 50;
  localparam int STORM_WINDOW_TICKS = STORM_WINDOW_MS * 1000 / TICK_PERIOD_US;

  localparam int NUM_PORTS = 6;
  localparam int LEN_W = 11;

  typedef logic [NUM_REGS-1:0][15:0] reg_bank_t;

  typedef struct packed {
    logic valid;
    logic [LEN_W-1:0] len_bytes;
  } frame_req_t;

endpackage : rate_storm_pkg

// ---- verilog/rate_bucket.sv ----
module rate_bucket #(
  parameter int BUCKET_W = 20
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic tick_i,
  input wire logic enable_i,
  input wire logic force_drop_i,
  input wire logic [rate_storm_pkg::RATE_W-1:0] rate_kbps_i,
  input wire rate_storm_pkg::frame_req_t req_i,
  output logic pass_o,
  output logic drop_o
);

  if (BUCKET_W < rate_storm_pkg::RATE_W + 2) begin : g_chk
    $error("rate_bucket: BUCKET_W too small for two ticks of credit");
  end

  logic [BUCKET_W-1:0] bucket;
  logic [BUCKET_W-1:0] cap;
  logic [BUCKET_W-1:0] credited;
  logic [BUCKET_W-1:0] cost;

  // One tick is 1 ms, so a rate in kbps adds that many bits per tick
  assign cap = BUCKET_W'({rate_kbps_i, 1'b0});
  assign cost = BUCKET_W'({req_i.len_bytes, 3'b000});

  always_comb begin
    credited = bucket;
    if (tick_i) begin
      credited = (bucket + BUCKET_W'(rate_kbps_i) > cap) ? cap :
                 bucket + BUCKET_W'(rate_kbps_i);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      bucket <= '0;
    end else if (!enable_i) begin
      bucket <= cap;
    end else if (req_i.valid && !force_drop_i && credited >= cost) begin
      bucket <= credited - cost; // RQ19
    end else begin
      bucket <= credited;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      pass_o <= 1'b0;
      drop_o <= 1'b0;
    end else begin
      pass_o <= req_i.valid && !force_drop_i &&
                (!enable_i || credited >= cost); // RQ19
      drop_o <= req_i.valid && (force_drop_i ||
                (enable_i && credited < cost)); // RQ19
    end
  end

endmodule : rate_bucket

// ---- verilog/storm_window.sv ----
module storm_window (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic tick_i,
  input wire logic enable_i,
  input wire logic [rate_storm_pkg::THRESH_W-1:0] threshold_i,
  input wire logic [2:0] rx_count_i,
  output logic storming_o
);

  localparam int CNT_W = rate_storm_pkg::THRESH_W + 1;

  logic [5:0] ticks;
  logic window_end;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;

  assign window_end = tick_i &&
    ticks == 6'(rate_storm_pkg::STORM_WINDOW_TICKS - 1);

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ticks <= '0;
    end else if (window_end) begin
      ticks <= '0;
    end else if (tick_i) begin
      ticks <= ticks + 6'h01;
    end
  end

  // Saturate rather than wrap so a heavy storm never looks quiet
  always_comb begin
    next_count = count + CNT_W'(rx_count_i);
    if (next_count < count) begin
      next_count = '1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      count <= '0;
    end else if (window_end) begin
      // Frames seen on the boundary cycle open the next window
      count <= CNT_W'(rx_count_i); // RQ20
    end else begin
      count <= next_count;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i || window_end || !enable_i) begin
      storming_o <= 1'b0; // RQ20 RQ14
    end else if (next_count > CNT_W'(threshold_i)) begin
      storming_o <= 1'b1; // RQ16 RQ17
    end
  end

endmodule : storm_window

// ---- verilog/rate_storm_filter.sv ----
module rate_storm_filter #(
  parameter int TICK_CYCLES = rate_storm_pkg::TICK_CYCLES,
  parameter int BUCKET_W = 20
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Register access port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  // Port link state from the MACs
  input wire logic [5:0] link_up_i,
  input wire logic [5:0] link_10m_i,
  // Frame requests from receive and transmit paths
  input wire rate_storm_pkg::frame_req_t [5:0] rx_req_i,
  input wire rate_storm_pkg::frame_req_t [5:0] tx_req_i,
  output logic [5:0] rx_pass_o,
  output logic [5:0] rx_drop_o,
  output logic [5:0] tx_pass_o,
  output logic [5:0] tx_drop_o,
  output logic storming_o
);

  if (TICK_CYCLES < 2 || TICK_CYCLES > 65535) begin : g_chk
    $error("rate_storm_filter: TICK_CYCLES out of range");
  end

  // ----------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------
  rate_storm_pkg::reg_bank_t regs;

  function automatic logic [15:0] write_mask(input int idx);
    if (idx == rate_storm_pkg::IDX_STORM0) begin
      return rate_storm_pkg::MASK_STORM0;
    end else if (idx == rate_storm_pkg::IDX_EXT6) begin
      return rate_storm_pkg::MASK_EXT6;
    end
    return 16'hffff;
  endfunction : write_mask

  function automatic logic hit(input logic [7:0] addr, input int idx);
    return addr == 8'(rate_storm_pkg::OFF_FIRST + idx);
  endfunction : hit

  for (genvar i = 0; i < rate_storm_pkg::NUM_REGS; i++) begin : g_reg
    always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
        regs[i] <= (i == rate_storm_pkg::IDX_EXT6) ?
                   rate_storm_pkg::RST_EXT6 :
                   rate_storm_pkg::RST_ZERO; // RQ13
      end else if (reg_wr_i && hit(reg_addr_i, i)) begin
        regs[i] <= reg_wdata_i & write_mask(i);
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= '0;
      for (int i = 0; i < rate_storm_pkg::NUM_REGS; i++) begin
        if (hit(reg_addr_i, i)) begin
          reg_rdata_o <= regs[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Limit assembly
  // ----------------------------------------------------------------
  function automatic logic [10:0] rx_limit(
    input rate_storm_pkg::reg_bank_t r,
    input int p
  );
    logic [3:0] lo;
    logic [3:0] mid;
    logic [2:0] hi;
    if (p < 4) begin
      lo = r[rate_storm_pkg::IDX_BASIC0][4*p +: 4]; // RQ18
      mid = r[rate_storm_pkg::IDX_EXT1][4*p +: 4]; // RQ7
    end else begin
      lo = r[rate_storm_pkg::IDX_BASIC1][4*(p-4) +: 4]; // RQ18
      mid = r[rate_storm_pkg::IDX_EXT2][4*(p-4) +: 4]; // RQ8
    end
    if (p < 5) begin
      hi = r[rate_storm_pkg::IDX_EXT4][3*p +: 3]; // RQ10
    end else begin
      hi = r[rate_storm_pkg::IDX_EXT5][2:0]; // RQ11
    end
    return {hi, mid, lo};
  endfunction : rx_limit

  function automatic logic [10:0] tx_limit(
    input rate_storm_pkg::reg_bank_t r,
    input int p
  );
    logic [3:0] lo;
    logic [3:0] mid;
    logic [2:0] hi;
    if (p < 2) begin
      lo = r[rate_storm_pkg::IDX_BASIC1][8+4*p +: 4]; // RQ18
      mid = r[rate_storm_pkg::IDX_EXT2][8+4*p +: 4]; // RQ8
    end else begin
      lo = r[rate_storm_pkg::IDX_EXT0][4*(p-2) +: 4]; // RQ5 RQ6
      mid = r[rate_storm_pkg::IDX_EXT3][4*(p-2) +: 4]; // RQ9
    end
    if (p < 4) begin
      hi = r[rate_storm_pkg::IDX_EXT5][3+3*p +: 3]; // RQ11
    end else begin
      hi = r[rate_storm_pkg::IDX_EXT6][3*(p-4) +: 3]; // RQ12
    end
    return {hi, mid, lo};
  endfunction : tx_limit

  // Older scheme only honours the four low bits of each limit
  function automatic logic [rate_storm_pkg::RATE_W-1:0] to_rate(
    input logic [10:0] limit,
    input logic new_scheme
  );
    logic [10:0] used;
    used = new_scheme ? limit : {7'h00, limit[3:0]}; // RQ1
    return {used, 6'h00}; // RQ4
  endfunction : to_rate

  logic new_scheme;
  assign new_scheme =
    regs[rate_storm_pkg::IDX_ENABLES][rate_storm_pkg::NEW_SCHEME_POS]; // RQ1

  // ----------------------------------------------------------------
  // Millisecond tick
  // ----------------------------------------------------------------
  logic [15:0] tick_cnt;
  logic tick;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else if (tick_cnt == 16'(TICK_CYCLES - 1)) begin
      tick_cnt <= '0;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
      tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Storm filter
  // ----------------------------------------------------------------
  logic [2:0] rx_count;
  logic any_10m;
  logic [rate_storm_pkg::THRESH_W-1:0] threshold;
  logic storm_drop;

  always_comb begin
    rx_count = 3'h0;
    for (int p = 0; p < rate_storm_pkg::NUM_PORTS; p++) begin
      rx_count = rx_count + 3'(rx_req_i[p].valid);
    end
  end

  assign any_10m = |(link_up_i & link_10m_i);
  assign threshold = any_10m ?
    regs[rate_storm_pkg::IDX_STORM1][rate_storm_pkg::THRESH_W-1:0] : // RQ17
    regs[rate_storm_pkg::IDX_STORM0][rate_storm_pkg::THRESH_W-1:0]; // RQ16

  storm_window u_storm (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .tick_i(tick),
    .enable_i(regs[rate_storm_pkg::IDX_STORM0][rate_storm_pkg::STORM_EN_POS]),
    .threshold_i(threshold),
    .rx_count_i(rx_count),
    .storming_o(storming_o)
  );

  assign storm_drop = storming_o &&
    regs[rate_storm_pkg::IDX_STORM0][rate_storm_pkg::STORM_DROP_POS]; // RQ15

  // ----------------------------------------------------------------
  // Per-port limiters
  // ----------------------------------------------------------------
  for (genvar p = 0; p < rate_storm_pkg::NUM_PORTS; p++) begin : g_port
    rate_bucket #(
      .BUCKET_W(BUCKET_W)
    ) u_rx (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .tick_i(tick),
      .enable_i(regs[rate_storm_pkg::IDX_ENABLES]
                [rate_storm_pkg::RX_EN_POS[p]]), // RQ3
      .force_drop_i(storm_drop),
      .rate_kbps_i(to_rate(rx_limit(regs, p), new_scheme)),
      .req_i(rx_req_i[p]),
      .pass_o(rx_pass_o[p]),
      .drop_o(rx_drop_o[p])
    );

    rate_bucket #(
      .BUCKET_W(BUCKET_W)
    ) u_tx (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .tick_i(tick),
      .enable_i(regs[rate_storm_pkg::IDX_ENABLES]
                [rate_storm_pkg::TX_EN_POS[p]]), // RQ2
      .force_drop_i(1'b0),
      .rate_kbps_i(to_rate(tx_limit(regs, p), new_scheme)),
      .req_i(tx_req_i[p]),
      .pass_o(tx_pass_o[p]),
      .drop_o(tx_drop_o[p])
    );
  end

endmodule : rate_storm_filter

// ---- verif/rate_storm_asserts.sv ----
module rate_storm_asserts #(
  parameter int TICK_CYCLES = 20,
  parameter int BUCKET_W = 20
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic [5:0] link_up_i,
  input wire logic [5:0] link_10m_i,
  input wire rate_storm_pkg::frame_req_t [5:0] rx_req_i,
  input wire rate_storm_pkg::frame_req_t [5:0] tx_req_i,
  input wire logic [5:0] rx_pass_o,
  input wire logic [5:0] rx_drop_o,
  input wire logic [5:0] tx_pass_o,
  input wire logic [5:0] tx_drop_o,
  input wire logic storming_o
);
  logic [5:0] rx_v;
  logic [5:0] tx_v;
  logic [15:0] en_sh;
  logic [15:0] st_sh;
  always_comb begin
    for (int p = 0; p < 6; p++) begin
      rx_v[p] = rx_req_i[p].valid;
      tx_v[p] = tx_req_i[p].valid;
    end
  end
  // Shadows of the enable and storm control words
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      en_sh <= 16'h0000;
    end else if (reg_wr_i && reg_addr_i == 8'h33) begin
      en_sh <= reg_wdata_i;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      st_sh <= 16'h0000;
    end else if (reg_wr_i && reg_addr_i == 8'h3b) begin
      st_sh <= reg_wdata_i;
    end
  end
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);
  chk_rx_answer: assert property (
    (rx_pass_o | rx_drop_o) == $past(rx_v) && (rx_pass_o & rx_drop_o) == 6'h00)
    else $error("rx answer mismatch");
  chk_tx_answer: assert property (
    (tx_pass_o | tx_drop_o) == $past(tx_v) && (tx_pass_o & tx_drop_o) == 6'h00)
    else $error("tx answer mismatch");
  chk_rx_unlimited: assert property (
    rx_v[0] && !en_sh[0] && !(storming_o && st_sh[14]) |=> rx_pass_o[0])
    else $error("unlimited rx frame not passed");
  chk_tx_unlimited: assert property (
    tx_v[5] && !en_sh[11] |=> tx_pass_o[5])
    else $error("unlimited tx frame not passed");
  chk_storm_gate: assert property (
    !st_sh[13] |=> !storming_o)
    else $error("storm flag without storm enable");
  chk_storm_drop: assert property (
    storming_o && st_sh[14] && rx_v[1] |=> rx_drop_o[1])
    else $error("storm frame not dropped");
  chk_rdata_hold: assert property (
    !reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without read");
  chk_unmapped_zero: assert property (
    reg_rd_i && (reg_addr_i < 8'h31 || reg_addr_i > 8'h3c)
    |=> reg_rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  chk_resv_bits: assert property (
    reg_rd_i && reg_addr_i == 8'h3a |=> reg_rdata_o[15:12] == 4'h0)
    else $error("reserved bits read nonzero");
endmodule : rate_storm_asserts

bind rate_storm_filter rate_storm_asserts #(
  .TICK_CYCLES(TICK_CYCLES), .BUCKET_W(BUCKET_W)
) rate_storm_asserts_inst (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .link_up_i(link_up_i), .link_10m_i(link_10m_i),
  .rx_req_i(rx_req_i), .tx_req_i(tx_req_i), .rx_pass_o(rx_pass_o),
  .rx_drop_o(rx_drop_o), .tx_pass_o(tx_pass_o), .tx_drop_o(tx_drop_o),
  .storming_o(storming_o)
);

// ---- verif/mac_side_model.sv ----
module mac_side_model (
  input wire logic send_i,
  input wire logic [5:0] rx_mask_i,
  input wire logic [5:0] tx_mask_i,
  input wire logic [10:0] len_i,
  output rate_storm_pkg::frame_req_t [5:0] rx_req_o,
  output rate_storm_pkg::frame_req_t [5:0] tx_req_o
);
  // Length field shows junk when no frame is offered
  always_comb begin
    for (int p = 0; p < 6; p++) begin
      rx_req_o[p].valid = send_i & rx_mask_i[p];
      tx_req_o[p].valid = send_i & tx_mask_i[p];
      rx_req_o[p].len_bytes = (send_i & rx_mask_i[p]) ? len_i : ~len_i;
      tx_req_o[p].len_bytes = (send_i & tx_mask_i[p]) ? len_i : ~len_i;
    end
  end
endmodule : mac_side_model

// ---- verif/testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 20;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic [15:0] reg_rdata_o;
  logic [5:0] link_up_i = 6'h3f;
  logic [5:0] link_10m_i = 6'h00;
  rate_storm_pkg::frame_req_t [5:0] rx_req_i;
  rate_storm_pkg::frame_req_t [5:0] tx_req_i;
  logic [5:0] rx_pass_o;
  logic [5:0] rx_drop_o;
  logic [5:0] tx_pass_o;
  logic [5:0] tx_drop_o;
  logic storming_o;
  logic send = 1'b0;
  logic [5:0] rx_mask = 6'h00;
  logic [5:0] tx_mask = 6'h00;
  logic [10:0] len = 11'h000;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;

  always #20 ref_clk_i = ~ref_clk_i;

  rate_storm_filter #(
    .TICK_CYCLES(TICK), .BUCKET_W(20)
  ) rate_storm_filter_inst (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .link_up_i(link_up_i), .link_10m_i(link_10m_i),
    .rx_req_i(rx_req_i), .tx_req_i(tx_req_i), .rx_pass_o(rx_pass_o),
    .rx_drop_o(rx_drop_o), .tx_pass_o(tx_pass_o), .tx_drop_o(tx_drop_o),
    .storming_o(storming_o)
  );
  mac_side_model mac_side_model_inst (
    .send_i(send), .rx_mask_i(rx_mask), .tx_mask_i(tx_mask), .len_i(len),
    .rx_req_o(rx_req_i), .tx_req_o(tx_req_i)
  );

  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask : rd
  // Offers n back-to-back frames; the last answer is settled on return
  task automatic frames(input logic [5:0] rm, input logic [5:0] tm,
                        input logic [10:0] l, input int n);
    @(posedge ref_clk_i);
    send <= 1'b1;
    rx_mask <= rm;
    tx_mask <= tm;
    len <= l;
    repeat (n - 1) @(posedge ref_clk_i);
    @(posedge ref_clk_i);
    send <= 1'b0;
    #1;
  endtask : frames
  task automatic wait_storm(input logic lvl);
    int k;
    k = 0;
    while (storming_o !== lvl && k < 1200) begin
      @(posedge ref_clk_i);
      #1 k++;
    end
    check({15'h0000, storming_o}, {15'h0000, lvl});
  endtask : wait_storm

  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      results();
    end
  end

  initial begin
    logic [15:0] d;
    logic [5:0] hot;
    repeat (3) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    for (int a = 8'h31; a <= 8'h3c; a++) begin
      rd(8'(a), d);
      check(d, a == 8'h3a ? 16'h0fc0 : 16'h0000);
    end
    for (int p = 0; p < 6; p++) begin
      hot = 6'h01 << p;
      wr(8'h33, (16'h0001 << rate_storm_pkg::TX_EN_POS[p])
                | (16'h0001 << rate_storm_pkg::RX_EN_POS[p]));
      frames(6'h3f, 6'h3f, 11'd64, 1);
      check({4'h0, rx_drop_o, rx_pass_o}, {4'h0, hot, ~hot});
      check({4'h0, tx_drop_o, tx_pass_o}, {4'h0, hot, ~hot});
    end
    for (int a = 8'h31; a <= 8'h3d; a++) begin
      wr(8'(a), 16'hffff);
      rd(8'(a), d);
      check(d, a == 8'h3b ? 16'h7fff : a == 8'h3a ? 16'h0fff
               : a == 8'h3d ? 16'h0000 : 16'hffff);
      wr(8'(a), 16'h0000);
    end
    rd(8'h30, d);
    check(d, 16'h0000);
    wr(8'h38, 16'h0001);
    wr(8'h33, 16'h0001);
    repeat (5 * TICK) @(posedge ref_clk_i);
    frames(6'h01, 6'h00, 11'd2047, 1);
    check({10'h000, rx_drop_o}, 16'h0001);
    wr(8'h33, 16'h1001);
    repeat (3 * TICK) @(posedge ref_clk_i);
    frames(6'h01, 6'h00, 11'd2047, 1);
    check({10'h000, rx_pass_o}, 16'h0001);
    wr(8'h38, 16'h0000);
    wr(8'h31, 16'h0001);
    repeat (6 * TICK) @(posedge ref_clk_i);
    frames(6'h01, 6'h00, 11'd17, 1);
    check({10'h000, rx_drop_o}, 16'h0001);
    frames(6'h01, 6'h00, 11'd16, 1);
    check({10'h000, rx_pass_o}, 16'h0001);
    frames(6'h01, 6'h00, 11'd16, 1);
    check({10'h000, rx_drop_o}, 16'h0001);
    wr(8'h34, 16'h0080);
    wr(8'h33, 16'h1200);
    frames(6'h00, 6'h08, 11'd129, 1);
    check({10'h000, tx_drop_o}, 16'h0008);
    frames(6'h00, 6'h08, 11'd128, 1);
    check({10'h000, tx_pass_o}, 16'h0008);
    wr(8'h33, 16'h0000);
    wr(8'h3b, 16'h6003);
    frames(6'h02, 6'h00, 11'd64, 6);
    wait_storm(1'b1);
    wait_storm(1'b0);
    frames(6'h02, 6'h00, 11'd64, 3);
    repeat (2) @(posedge ref_clk_i);
    #1;
    check({15'h0000, storming_o}, 16'h0000);
    frames(6'h02, 6'h00, 11'd64, 1);
    repeat (2) @(posedge ref_clk_i);
    #1;
    check({15'h0000, storming_o}, 16'h0001);
    frames(6'h02, 6'h00, 11'd64, 1);
    check({10'h000, rx_drop_o}, 16'h0002);
    wr(8'h3b, 16'h2003);
    frames(6'h02, 6'h00, 11'd64, 1);
    check({10'h000, rx_pass_o}, 16'h0002);
    wr(8'h3b, 16'h0003);
    link_10m_i <= 6'h04;
    repeat (2) @(posedge ref_clk_i);
    #1;
    check({15'h0000, storming_o}, 16'h0000);
    wr(8'h3c, 16'h0001);
    wr(8'h3b, 16'h6100);
    frames(6'h02, 6'h00, 11'd64, 3);
    repeat (2) @(posedge ref_clk_i);
    #1;
    check({15'h0000, storming_o}, 16'h0001);
    results();
  end
endmodule : testbench
